//--- core/pmc_pkg.sv
`default_nettype none
package pmc_pkg;
    localparam logic [7:0] OFF_TXV_HIGH  = 8'h3a;
    localparam logic [7:0] OFF_TXV_LOW   = 8'h3b;
    localparam logic [7:0] OFF_HOLD      = 8'h3c;
    localparam logic [7:0] OFF_FLAGS     = 8'h3d;
    localparam logic [7:0] OFF_VIOL_HIGH = 8'h3e;
    localparam logic [7:0] OFF_VIOL_LOW  = 8'h3f;
    localparam logic [7:0] OFF_PAR_HIGH  = 8'h40;
    localparam logic [7:0] OFF_PAR_LOW   = 8'h41;
    localparam int FLAG_ES_BIT  = 1;
    localparam int FLAG_SES_BIT = 0;
    localparam logic [7:0]  RESET_BYTE   = 8'h00;
    localparam logic [15:0] RESET_COUNT  = 16'h0000;
    // One second at 100 MHz
    localparam int CLK_PERIOD_NS = 10;
    localparam int SECOND_NS     = 1000000000;
    localparam int SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;
    // Severe threshold: more than one error per 10,000 bits
    localparam int SES_RATIO     = 10000;
    localparam int DS3_BITS_PER_SECOND = 44736000;
    localparam int SES_LIMIT_DEFAULT   = DS3_BITS_PER_SECOND / SES_RATIO;
endpackage
`default_nettype wire

//--- core/pmc_sat_counter.sv
`timescale 1ns/100ps
`default_nettype none
// Saturating 16-bit event counter with restart
module pmc_sat_counter
    import pmc_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Control
    input  wire logic        restart,
    input  wire logic        event_in,
    // Count
    output logic [15:0]      count
);
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count <= RESET_COUNT;
        end else if (restart) begin
            // An event in the restart cycle opens the new count
            count <= event_in ? 16'h0001 : 16'h0000;
        end else if (event_in && count != 16'hffff) begin
            count <= count + 16'h0001;
        end
    end
endmodule
`default_nettype wire

//--- core/pmc_perf_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Valid cells sent are counted in 16 bits, low byte at 0x3b, cleared when read.
// - The valid cell count only advances while ATM UNI mode is selected.
// - With an 8-bit bus, reading one byte of a 16-bit value puts its partner byte at 0x3c.
// - Errored-second flag, bit 1, is set when any error occurred in the last completed second.
// - Severely-errored-second flag, bit 0, is set when errors exceed one in ten thousand.
// - Line code violations of the last second are readable at 0x3e (high) and 0x3f (low).
// - Parity errors of the last second are readable at 0x40 (high) and 0x41 (low).
module pmc_perf_monitor
    import pmc_pkg::*;
#(
    parameter int SECOND_LEN = SECOND_CYCLES,
    parameter int SES_LIMIT  = SES_LIMIT_DEFAULT
)
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Configuration
    input  wire logic        atm_uni_mode,
    input  wire logic        bus_8bit,
    // Events from datapath, one-cycle pulses on ref_clk
    input  wire logic        tx_valid_cell,
    input  wire logic        line_code_violation,
    input  wire logic        parity_error,
    // Host register port
    input  wire logic        rd_strobe,
    input  wire logic [7:0]  rd_addr,
    output logic [7:0]       rd_data,
    // Status
    output logic             second_tick
);
    import pmc_pkg::*;

    logic [31:0] sec_count;
    logic [15:0] txv_count;
    logic [15:0] viol_run;
    logic [15:0] par_run;
    logic [15:0] viol_acc;
    logic [15:0] par_acc;
    logic [1:0]  flags;
    logic [7:0]  hold;
    logic        txv_read;
    logic [15:0] next_txv;

    function automatic logic [7:0] pick(input logic [15:0] v, input logic high);
        pick = high ? v[15:8] : v[7:0];
    endfunction

    // Second timer
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sec_count   <= 32'h0000_0000;
            second_tick <= 1'b0;
        end else if (sec_count == 32'(SECOND_LEN - 1)) begin
            sec_count   <= 32'h0000_0000;
            second_tick <= 1'b1;
        end else begin
            sec_count   <= sec_count + 32'h0000_0001;
            second_tick <= 1'b0;
        end
    end

    logic boundary;
    assign boundary = (sec_count == 32'(SECOND_LEN - 1));

    // Running error counts for the current second
    pmc_sat_counter u_viol (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .restart  (boundary),
        .event_in (line_code_violation),
        .count    (viol_run)
    );
    pmc_sat_counter u_par (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .restart  (boundary),
        .event_in (parity_error),
        .count    (par_run)
    );

    // Latched results of the last completed second
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            viol_acc <= RESET_COUNT;
            par_acc  <= RESET_COUNT;
            flags    <= 2'b00;
        end else if (boundary) begin
            viol_acc <= viol_run;
            par_acc  <= par_run;
            flags[FLAG_ES_BIT]  <= (viol_run != 16'h0000) || (par_run != 16'h0000);
            flags[FLAG_SES_BIT] <= (32'(viol_run) + 32'(par_run)) > 32'(SES_LIMIT);
        end
    end

    // Transmit valid cell counter, cleared on a read of either byte
    assign txv_read = rd_strobe && (rd_addr == OFF_TXV_LOW || rd_addr == OFF_TXV_HIGH);

    always_comb begin
        next_txv = txv_count;
        if (txv_read) begin
            // A cell in the read cycle survives the clear
            next_txv = (atm_uni_mode && tx_valid_cell) ? 16'h0001 : 16'h0000;
        end else if (atm_uni_mode && tx_valid_cell && txv_count != 16'hffff) begin
            next_txv = txv_count + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            txv_count <= RESET_COUNT;
        end else begin
            txv_count <= next_txv;
        end
    end

    // Read data and companion byte holding
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_data <= RESET_BYTE;
            hold    <= RESET_BYTE;
        end else if (rd_strobe) begin
            if (rd_addr == OFF_TXV_LOW) begin
                rd_data <= pick(txv_count, 1'b0);
                if (bus_8bit) begin
                    hold <= pick(txv_count, 1'b1);
                end
            end else if (rd_addr == OFF_TXV_HIGH) begin
                rd_data <= pick(txv_count, 1'b1);
                if (bus_8bit) begin
                    hold <= pick(txv_count, 1'b0);
                end
            end else if (rd_addr == OFF_HOLD) begin
                rd_data <= hold;
            end else if (rd_addr == OFF_FLAGS) begin
                rd_data <= {6'h00, flags};
            end else if (rd_addr == OFF_VIOL_HIGH) begin
                rd_data <= pick(viol_acc, 1'b1);
                if (bus_8bit) begin
                    hold <= pick(viol_acc, 1'b0);
                end
            end else if (rd_addr == OFF_VIOL_LOW) begin
                rd_data <= pick(viol_acc, 1'b0);
                if (bus_8bit) begin
                    hold <= pick(viol_acc, 1'b1);
                end
            end else if (rd_addr == OFF_PAR_HIGH) begin
                rd_data <= pick(par_acc, 1'b1);
                if (bus_8bit) begin
                    hold <= pick(par_acc, 1'b0);
                end
            end else if (rd_addr == OFF_PAR_LOW) begin
                rd_data <= pick(par_acc, 1'b0);
                if (bus_8bit) begin
                    hold <= pick(par_acc, 1'b1);
                end
            end else begin
                rd_data <= RESET_BYTE;
            end
        end
    end

    // Checks
    property p_txv_count;
        @(posedge ref_clk) disable iff (rst)
        (!txv_read && atm_uni_mode && tx_valid_cell && txv_count != 16'hffff)
            |=> txv_count == $past(txv_count) + 16'h0001;
    endproperty
    a_txv_count: assert property (p_txv_count) else $error("valid cell count missed");

    property p_txv_clear;
        @(posedge ref_clk) disable iff (rst)
        (txv_read && !tx_valid_cell) |=> txv_count == 16'h0000;
    endproperty
    a_txv_clear: assert property (p_txv_clear) else $error("count not cleared on read");

    property p_txv_mode;
        @(posedge ref_clk) disable iff (rst)
        (!atm_uni_mode && !txv_read) |=> $stable(txv_count);
    endproperty
    a_txv_mode: assert property (p_txv_mode) else $error("count moved outside ATM mode");

    property p_hold;
        @(posedge ref_clk) disable iff (rst)
        (rd_strobe && bus_8bit && rd_addr == OFF_VIOL_HIGH) |=> hold == $past(viol_acc[7:0]);
    endproperty
    a_hold: assert property (p_hold) else $error("companion byte not held");

    property p_es;
        @(posedge ref_clk) disable iff (rst)
        (boundary && viol_run == 16'h0000 && par_run == 16'h0000) |=> !flags[FLAG_ES_BIT];
    endproperty
    a_es: assert property (p_es) else $error("errored second set without errors");

    property p_ses;
        @(posedge ref_clk) disable iff (rst)
        flags[FLAG_SES_BIT] |-> flags[FLAG_ES_BIT];
    endproperty
    a_ses: assert property (p_ses) else $error("severe flag without errored flag");

    property p_viol_acc;
        @(posedge ref_clk) disable iff (rst)
        boundary |=> viol_acc == $past(viol_run);
    endproperty
    a_viol_acc: assert property (p_viol_acc) else $error("violation total not latched");

    property p_par_read;
        @(posedge ref_clk) disable iff (rst)
        (rd_strobe && rd_addr == OFF_PAR_HIGH) |=> rd_data == $past(par_acc[15:8]);
    endproperty
    a_par_read: assert property (p_par_read) else $error("parity high byte wrong");

    property p_restart;
        @(posedge ref_clk) disable iff (rst)
        (boundary && !line_code_violation) |=> viol_run == 16'h0000 && second_tick;
    endproperty
    a_restart: assert property (p_restart) else $error("running count not restarted");

    property p_txv_low;
        @(posedge ref_clk) disable iff (rst)
        (rd_strobe && rd_addr == OFF_TXV_LOW) |=> rd_data == $past(txv_count[7:0]);
    endproperty
    a_txv_low: assert property (p_txv_low) else $error("cell low byte wrong");

    property p_txv_high;
        @(posedge ref_clk) disable iff (rst)
        (rd_strobe && rd_addr == OFF_TXV_HIGH) |=> rd_data == $past(txv_count[15:8]);
    endproperty
    a_txv_high: assert property (p_txv_high) else $error("cell high byte wrong");

    property p_hold_txv;
        @(posedge ref_clk) disable iff (rst)
        (rd_strobe && bus_8bit && rd_addr == OFF_TXV_LOW) |=> hold == $past(txv_count[15:8]);
    endproperty
    a_hold_txv: assert property (p_hold_txv) else $error("cell companion wrong");

    property p_hold_viol;
        @(posedge ref_clk) disable iff (rst)
        (rd_strobe && bus_8bit && rd_addr == OFF_VIOL_LOW) |=> hold == $past(viol_acc[15:8]);
    endproperty
    a_hold_viol: assert property (p_hold_viol) else $error("violation companion wrong");

    property p_hold_par;
        @(posedge ref_clk) disable iff (rst)
        (rd_strobe && bus_8bit && rd_addr == OFF_PAR_LOW) |=> hold == $past(par_acc[15:8]);
    endproperty
    a_hold_par: assert property (p_hold_par) else $error("parity companion wrong");

    property p_hold_keep;
        @(posedge ref_clk) disable iff (rst)
        !(rd_strobe && bus_8bit) |=> $stable(hold);
    endproperty
    a_hold_keep: assert property (p_hold_keep) else $error("holding byte moved");

    property p_hold_out;
        @(posedge ref_clk) disable iff (rst)
        (rd_strobe && rd_addr == OFF_HOLD) |=> rd_data == $past(hold);
    endproperty
    a_hold_out: assert property (p_hold_out) else $error("holding read wrong");

    property p_es_set;
        @(posedge ref_clk) disable iff (rst)
        (boundary && (viol_run != 16'h0000 || par_run != 16'h0000)) |=> flags[FLAG_ES_BIT];
    endproperty
    a_es_set: assert property (p_es_set) else $error("errored second missed");

    // Written from the running counts, so a wrong limit compare shows up here
    property p_ses_set;
        @(posedge ref_clk) disable iff (rst)
        boundary |=> flags[FLAG_SES_BIT] ==
            ((32'($past(viol_run)) + 32'($past(par_run))) > 32'(SES_LIMIT));
    endproperty
    a_ses_set: assert property (p_ses_set) else $error("severe flag wrong");

    property p_flags_out;
        @(posedge ref_clk) disable iff (rst)
        (rd_strobe && rd_addr == OFF_FLAGS) |=> rd_data == {6'h00, $past(flags)};
    endproperty
    a_flags_out: assert property (p_flags_out) else $error("flag read wrong");

    property p_flags_keep;
        @(posedge ref_clk) disable iff (rst)
        !boundary |=> $stable(flags);
    endproperty
    a_flags_keep: assert property (p_flags_keep) else $error("flags moved");

    property p_viol_low;
        @(posedge ref_clk) disable iff (rst)
        (rd_strobe && rd_addr == OFF_VIOL_LOW) |=> rd_data == $past(viol_acc[7:0]);
    endproperty
    a_viol_low: assert property (p_viol_low) else $error("violation low byte wrong");

    property p_par_acc;
        @(posedge ref_clk) disable iff (rst)
        boundary |=> par_acc == $past(par_run);
    endproperty
    a_par_acc: assert property (p_par_acc) else $error("parity total not latched");

    property p_acc_keep;
        @(posedge ref_clk) disable iff (rst)
        !boundary |=> $stable(viol_acc) && $stable(par_acc);
    endproperty
    a_acc_keep: assert property (p_acc_keep) else $error("totals moved mid-second");

    property p_tick;
        @(posedge ref_clk) disable iff (rst)
        boundary |=> second_tick;
    endproperty
    a_tick: assert property (p_tick) else $error("second pulse missing");

endmodule
`default_nettype wire

//--- verif/pmc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// Host processor on the 8-bit parallel register port
module pmc_host_model
    import pmc_pkg::*;
(
    // Clock
    input  wire logic       ref_clk,
    // Register port
    input  wire logic [7:0] rd_data,
    output logic            rd_strobe,
    output logic [7:0]      rd_addr
);
    initial begin
        rd_strobe = 1'b0;
        rd_addr   = 8'h00;
    end
    // Address is inverted on release so a stale offset never looks selected
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        rd_strobe <= 1'b1;
        rd_addr   <= a;
        @(posedge ref_clk);
        rd_strobe <= 1'b0;
        rd_addr   <= ~a;
        #1 d = rd_data;
    endtask
    // Low byte first, then the companion byte from the holding register
    task automatic rd16(input logic [7:0] a, output logic [15:0] v);
        rd(a, v[7:0]);
        rd(OFF_HOLD, v[15:8]);
    endtask
endmodule
`default_nettype wire

//--- verif/tb_pmc_perf_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module tb_pmc_perf_monitor;
    import pmc_pkg::*;
    localparam int SEC = 100;
    localparam int LIM = 5;
    logic       ref_clk = 1'b0;
    logic       rst = 1'b1;
    logic       atm_uni_mode = 1'b0;
    logic       bus_8bit = 1'b1;
    logic       tx_valid_cell = 1'b0;
    logic       line_code_violation = 1'b0;
    logic       parity_error = 1'b0;
    logic       rd_strobe;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic       second_tick;
    int         mismatches = 0;
    int         n_tests = 0;
    logic [7:0]  d;
    logic [15:0] v;
    always #5 ref_clk = ~ref_clk;
    pmc_perf_monitor #(.SECOND_LEN(SEC), .SES_LIMIT(LIM)) i_pmc_perf_monitor (
        .ref_clk(ref_clk), .rst(rst), .atm_uni_mode(atm_uni_mode), .bus_8bit(bus_8bit),
        .tx_valid_cell(tx_valid_cell), .line_code_violation(line_code_violation),
        .parity_error(parity_error), .rd_strobe(rd_strobe), .rd_addr(rd_addr),
        .rd_data(rd_data), .second_tick(second_tick));
    pmc_host_model i_pmc_host_model (.ref_clk(ref_clk), .rd_data(rd_data),
        .rd_strobe(rd_strobe), .rd_addr(rd_addr));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cells(input int n);
        repeat (n) @(posedge ref_clk) tx_valid_cell <= 1'b1;
        @(posedge ref_clk) tx_valid_cell <= 1'b0;
    endtask
    // Bounded wait for the one-second pulse
    task automatic wait_tick;
        int k;
        k = 0;
        do begin
            @(posedge ref_clk);
            #1 k++;
        end while (second_tick !== 1'b1 && k < 3 * SEC);
        chk({15'h0, second_tick}, 16'h0001, "second tick");
    endtask
    task automatic t_reset;
        logic [7:0] offs [9];
        offs = '{OFF_TXV_LOW, OFF_HOLD, OFF_FLAGS, OFF_VIOL_HIGH, OFF_VIOL_LOW,
                 OFF_PAR_HIGH, OFF_PAR_LOW, 8'h50, OFF_TXV_HIGH};
        foreach (offs[i]) begin
            i_pmc_host_model.rd(offs[i], d);
            chk({8'h0, d}, 16'h0000, "reset value");
        end
        $display("test reset done");
    endtask
    task automatic t_cells;
        @(posedge ref_clk) atm_uni_mode <= 1'b1;
        cells(300);
        i_pmc_host_model.rd16(OFF_TXV_LOW, v);
        chk(v, 16'h012c, "cell count");
        i_pmc_host_model.rd(OFF_TXV_LOW, d);
        chk({8'h0, d}, 16'h0000, "cleared on read");
        @(posedge ref_clk) atm_uni_mode <= 1'b0;
        cells(5);
        i_pmc_host_model.rd(OFF_TXV_LOW, d);
        chk({8'h0, d}, 16'h0000, "count outside ATM mode");
        $display("test cells done");
    endtask
    // The holding byte follows reads only on an 8-bit bus
    task automatic t_wide;
        @(posedge ref_clk) atm_uni_mode <= 1'b1;
        cells(258);
        i_pmc_host_model.rd(OFF_TXV_HIGH, d);
        chk({8'h0, d}, 16'h0001, "cell count high byte");
        i_pmc_host_model.rd(OFF_HOLD, d);
        chk({8'h0, d}, 16'h0002, "cell count companion");
        @(posedge ref_clk) bus_8bit <= 1'b0;
        cells(3);
        i_pmc_host_model.rd(OFF_TXV_LOW, d);
        chk({8'h0, d}, 16'h0003, "cell count wide bus");
        i_pmc_host_model.rd(OFF_HOLD, d);
        chk({8'h0, d}, 16'h0002, "holding kept on wide bus");
        @(posedge ref_clk) begin
            bus_8bit <= 1'b1;
            atm_uni_mode <= 1'b0;
        end
        $display("test wide bus done");
    endtask
    // Total 5 sits on the severe limit and must not flag it
    task automatic t_errors;
        int nl [3] = '{0, 3, 5};
        int np [3] = '{0, 2, 1};
        for (int c = 0; c < 3; c++) begin
            wait_tick();
            for (int i = 0; i < 8; i++) begin
                @(posedge ref_clk);
                line_code_violation <= (i < nl[c]);
                parity_error <= (i < np[c]);
            end
            wait_tick();
            i_pmc_host_model.rd16(OFF_VIOL_LOW, v);
            chk(v, 16'(nl[c]), "violations");
            i_pmc_host_model.rd16(OFF_PAR_LOW, v);
            chk(v, 16'(np[c]), "parity errors");
            i_pmc_host_model.rd(OFF_FLAGS, d);
            chk({8'h0, d}, {14'h0, nl[c] + np[c] > 0, nl[c] + np[c] > LIM}, "flags");
            i_pmc_host_model.rd(OFF_VIOL_HIGH, d);
            chk({8'h0, d}, 16'h0000, "violations high byte");
            i_pmc_host_model.rd(OFF_HOLD, d);
            chk({8'h0, d}, 16'(nl[c]), "violations companion");
            i_pmc_host_model.rd(OFF_PAR_HIGH, d);
            chk({8'h0, d}, 16'h0000, "parity high byte");
            i_pmc_host_model.rd(OFF_HOLD, d);
            chk({8'h0, d}, 16'(np[c]), "parity companion");
        end
        $display("test errors done");
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_cells();
        t_wide();
        t_errors();
        conclude();
    end
    initial begin
        #(20000 * 10);
        mismatches++;
        conclude();
    end
endmodule
`default_nettype wire
